/* File: exec_timing_map.vh */
// Constants for the long move, add/subtract-one and compare unit.
// Assumes the includer has already set its own net type rules.
// Contract
// - Register or even internal RAM operands add zero cycles, any size.
// - Odd internal RAM adds 0 byte, 1 word, 2 long cycles.
// - Even address outside internal RAM adds 1 byte/word, 2 long.
// - Odd address outside internal RAM adds 1 byte, 3 word, 6 long.
// - Eight-bit external data bus adds 1 byte, 3 word, 6 long.
// - Long register into accumulator: 2 bytes, 1 cycle, no correction.
// - Accumulator from stack pointer plus offset: 3 bytes, 4 cycles, long.
// - Accumulator from physical address: 5 bytes, 4 cycles plus long.
// - Accumulator loaded through its own address: 2 bytes, 3 plus long.
// - Accumulator into long register: 2 bytes, 2 cycles, no correction.
// - Accumulator to memory: 2+ bytes, 3 plus mode plus long cycles.
// - Long transfers set only negative and zero from the moved value.
// - Byte add/subtract-one register: 2 bytes, 2 cycles, NZV, keep carry.
// - Byte add/subtract-one memory: 3 plus mode plus twice byte.
// - Word add/subtract-one: 2 register; 3 plus mode plus twice word.
// - Long add/subtract-one register: 2 bytes, 4 cycles, NZV, keep C.
// - Long add/subtract-one memory: 5 plus mode plus twice long.
// - Compares subtract without storing, set NZVC; halves form AH-AL.
// - Correction column chosen by operand size, counted into total.
// - Post-increment indirect adds 4; plain indirect or direct adds 1.
`ifndef EXEC_TIMING_MAP_VH
`define EXEC_TIMING_MAP_VH

// Operation codes
`define OP_LOAD_EA 4'h0
`define OP_LOAD_IMM 4'h1
`define OP_LOAD_STACK 4'h2
`define OP_LOAD_PHYS 4'h3
`define OP_LOAD_IND 4'h4
`define OP_STORE_IND 4'h5
`define OP_STORE_STACK 4'h6
`define OP_STORE_PHYS 4'h7
`define OP_STORE_EA 4'h8
`define OP_ADD_ONE 4'h9
`define OP_SUB_ONE 4'ha
`define OP_CMP_EA 4'hb
`define OP_CMP_IMM 4'hc
`define OP_CMP_HALVES 4'hd

// Operand sizes
`define SIZE_BYTE 2'h0
`define SIZE_WORD 2'h1
`define SIZE_LONG 2'h2

// Operand locations
`define LOC_REG 3'h0
`define LOC_RAM_EVEN 3'h1
`define LOC_RAM_ODD 3'h2
`define LOC_EXT_EVEN 3'h3
`define LOC_EXT_ODD 3'h4
`define LOC_BUS8 3'h5

// Location corrections, byte / word / long
`define CORR_ZERO 6'h00
`define CORR_RAM_ODD_W 6'h01
`define CORR_RAM_ODD_L 6'h02
`define CORR_EXT_EVEN_BW 6'h01
`define CORR_EXT_EVEN_L 6'h02
`define CORR_ODD_B 6'h01
`define CORR_ODD_W 6'h03
`define CORR_ODD_L 6'h06

// Addressing mode boundaries and their extra cycles
`define MODE_MEM_FIRST 5'h08
`define MODE_POSTINC_FIRST 5'h0c
`define MODE_OFFSET8_FIRST 5'h10
`define MODE_DISP16_FIRST 5'h18
`define MODE_INDEX_FIRST 5'h1c
`define MODE_DIRECT16 5'h1f
`define MODE_CYC_PLAIN 6'h01
`define MODE_CYC_POSTINC 6'h04
`define MODE_CYC_INDEX 6'h02

// Base cycle counts
`define CYC_LOAD_REG 6'h01
`define CYC_LOAD_MEM 6'h03
`define CYC_LOAD_IMM 6'h03
`define CYC_STACK 6'h04
`define CYC_PHYS 6'h04
`define CYC_LOAD_IND 6'h03
`define CYC_STORE_IND 6'h05
`define CYC_STORE_REG 6'h02
`define CYC_STORE_MEM 6'h03
`define CYC_STEP_REG_BW 6'h02
`define CYC_STEP_REG_L 6'h04
`define CYC_STEP_MEM_BW 6'h03
`define CYC_STEP_MEM_L 6'h05
`define CYC_CMP_REG_BW 6'h02
`define CYC_CMP_REG_L 6'h03
`define CYC_CMP_MEM_BW 6'h02
`define CYC_CMP_MEM_L 6'h04
`define CYC_CMP_IMM_BW 6'h02
`define CYC_CMP_IMM_L 6'h03
`define CYC_CMP_HALVES 6'h02

// Instruction lengths in bytes
`define LEN_ONE 4'h1
`define LEN_TWO 4'h2
`define LEN_THREE 4'h3
`define LEN_FIVE 4'h5

// Reset values
`define ACC_RESET 32'h00000000

`endif

/* File: lmsc_asserts.sv */
// Port checker for the long move, add/subtract-one and compare unit.
// Assumes it is bound to the unit's top and sees only its ports.
`default_nettype none
`include "exec_timing_map.vh"
module lmsc_asserts (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic START,
  input wire logic [3:0] OP,
  input wire logic [1:0] SIZE,
  input wire logic [4:0] MODE,
  input wire logic [2:0] LOC,
  input wire logic [31:0] OPERAND,
  input wire logic BUSY,
  input wire logic DONE,
  input wire logic [31:0] ACC,
  input wire logic [31:0] WRITE_DATA,
  input wire logic WRITE_EN,
  input wire logic READ_MODIFY_WRITE_ATTR,
  input wire logic [23:0] PHYS_ADDR,
  input wire logic [5:0] CYCLES,
  input wire logic [5:0] CORRECTION,
  input wire logic [3:0] LENGTH,
  input wire logic FLAG_N,
  input wire logic FLAG_Z,
  input wire logic FLAG_V,
  input wire logic FLAG_C
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);
  logic [5:0] busy_cnt;
  logic [3:0] op_q;
  logic v_q;
  logic c_q;
  logic [31:0] acc_q;
  wire take = START && !BUSY;
  wire step = (op_q == `OP_ADD_ONE) || (op_q == `OP_SUB_ONE);
  wire move = (op_q <= `OP_STORE_EA);
  // Snapshot at the taking edge; count counts busy cycles since then
  always @(posedge REF_CLK) begin
    if (RST) begin
      busy_cnt <= 6'h00;
      op_q <= 4'h0;
      v_q <= 1'b0;
      c_q <= 1'b0;
      acc_q <= 32'h0;
    end else if (take) begin
      busy_cnt <= 6'h00;
      op_q <= OP;
      v_q <= FLAG_V;
      c_q <= FLAG_C;
      acc_q <= ACC;
    end else if (BUSY) begin
      busy_cnt <= busy_cnt + 6'h01;
    end
  end
  sequence take_s;
    START && !BUSY;
  endsequence
  sequence busy_end_s;
    BUSY ##1 !BUSY;
  endsequence
  take_busy_a: assert property (take_s |=> BUSY && !DONE)
    else $error("busy did not follow an accepted start");
  busy_done_a: assert property (busy_end_s |-> DONE)
    else $error("busy ended without done");
  cycle_count_a: assert property (DONE |-> busy_cnt == CYCLES)
    else $error("busy length differs from reported cycles");
  busy_bound_a: assert property (BUSY |-> busy_cnt < 6'h15)
    else $error("busy ran past the longest instruction");
  move_vc_kept_a: assert property (DONE && move |->
      FLAG_V == v_q && FLAG_C == c_q)
    else $error("long move changed overflow or carry");
  move_nz_a: assert property (
      DONE && move && op_q != `OP_STORE_IND |->
      FLAG_N == ACC[31] && FLAG_Z == (ACC == 32'h0))
    else $error("long move negative or zero wrong");
  step_carry_a: assert property (DONE && step |-> FLAG_C == c_q)
    else $error("add or subtract one changed carry");
  modify_attr_a: assert property (
      READ_MODIFY_WRITE_ATTR == (BUSY && step))
    else $error("read-modify-write marker wrong");
  wen_done_a: assert property (WRITE_EN |-> DONE)
    else $error("write strobe outside commit cycle");
  phys_addr_a: assert property (BUSY |-> PHYS_ADDR == acc_q[23:0])
    else $error("physical address not the accumulator at start");
  cmp_acc_kept_a: assert property (DONE && op_q >= `OP_CMP_EA |->
      ACC == acc_q)
    else $error("compare changed the accumulator");
endmodule
`default_nettype wire

/* File: location_correction.v */
// Location correction lookup: extra cycles by operand place and size.
// Assumes codes from the timing map; purely combinational.
`include "exec_timing_map.vh"
`default_nettype none
module location_correction (
  input wire [2:0] loc,
  input wire [1:0] size,
  output reg [5:0] corr
);
  // One column per size, picked by the operand size
  always @* begin
    corr = `CORR_ZERO;
    case (loc)
      `LOC_REG, `LOC_RAM_EVEN: corr = `CORR_ZERO;
      `LOC_RAM_ODD: begin
        if (size == `SIZE_LONG) corr = `CORR_RAM_ODD_L;
        else if (size == `SIZE_WORD) corr = `CORR_RAM_ODD_W;
        else corr = `CORR_ZERO;
      end
      `LOC_EXT_EVEN: begin
        if (size == `SIZE_LONG) corr = `CORR_EXT_EVEN_L;
        else corr = `CORR_EXT_EVEN_BW;
      end
      `LOC_EXT_ODD, `LOC_BUS8: begin
        // Eight-bit bus costs the same whatever the alignment
        if (size == `SIZE_LONG) corr = `CORR_ODD_L;
        else if (size == `SIZE_WORD) corr = `CORR_ODD_W;
        else corr = `CORR_ODD_B;
      end
      default: corr = `CORR_ZERO;
    endcase
  end
endmodule
`default_nettype wire

/* File: long_move_step_compare.v */
// Execution unit for long moves, add/subtract-one and compares.
// Assumes the fetch side supplies the decoded operation, operand value,
// addressing mode and operand location, all on REF_CLK.
`include "exec_timing_map.vh"
`default_nettype none
module long_move_step_compare (
  input wire REF_CLK,
  input wire RST,
  input wire START,
  input wire [3:0] OP,
  input wire [1:0] SIZE,
  input wire [4:0] MODE,
  input wire [2:0] LOC,
  input wire [31:0] OPERAND,
  output reg BUSY,
  output reg DONE,
  output reg [31:0] ACC,
  output reg [31:0] WRITE_DATA,
  output reg WRITE_EN,
  output reg READ_MODIFY_WRITE_ATTR,
  output reg [23:0] PHYS_ADDR,
  output reg [5:0] CYCLES,
  output reg [5:0] CORRECTION,
  output reg [3:0] LENGTH,
  output reg FLAG_N,
  output reg FLAG_Z,
  output reg FLAG_V,
  output reg FLAG_C
);

  localparam ST_IDLE = 2'b01;
  localparam ST_BUSY = 2'b10;

  reg [1:0] state;
  reg [3:0] op;
  reg [1:0] size;
  reg [31:0] operand;
  reg [5:0] count;
  reg [5:0] total;

  wire [5:0] corr;
  wire [31:0] alu_result;
  wire alu_n;
  wire alu_z;
  wire alu_v;
  wire alu_c;

  reg [1:0] corr_size;
  reg in_memory;
  reg [5:0] mode_cycles;
  reg [3:0] ext_bytes;
  reg [5:0] next_total;
  reg [5:0] next_corr;
  reg [3:0] next_length;
  reg [31:0] alu_a;
  reg [31:0] alu_b;
  reg alu_sub;
  reg [1:0] alu_size;

  // Transfers are always long; a long halves compare uses word; the rest use their own size
  always @* begin
    corr_size = SIZE;
    if (OP <= `OP_STORE_EA) corr_size = `SIZE_LONG;
    if (OP == `OP_CMP_HALVES && SIZE == `SIZE_LONG) corr_size = `SIZE_WORD;
  end

  location_correction u_corr (
    .loc(LOC),
    .size(corr_size),
    .corr(corr)
  );

  // Addressing mode cycles and extension bytes
  always @* begin
    in_memory = (MODE >= `MODE_MEM_FIRST);
    mode_cycles = `MODE_CYC_PLAIN;
    ext_bytes = 4'h0;
    if (MODE >= `MODE_POSTINC_FIRST && MODE < `MODE_OFFSET8_FIRST)
      mode_cycles = `MODE_CYC_POSTINC;
    if (MODE >= `MODE_INDEX_FIRST && MODE != `MODE_DIRECT16)
      mode_cycles = `MODE_CYC_INDEX;
    if (MODE >= `MODE_OFFSET8_FIRST && MODE < `MODE_DISP16_FIRST)
      ext_bytes = 4'h1;
    else if (MODE >= `MODE_DISP16_FIRST && MODE < `MODE_INDEX_FIRST)
      ext_bytes = 4'h2;
    else if (MODE == `MODE_INDEX_FIRST + 5'h02 || MODE == `MODE_DIRECT16)
      ext_bytes = 4'h2;
    if (!in_memory) begin
      mode_cycles = 6'h00;
      ext_bytes = 4'h0;
    end
  end

  // Total cycles, correction and length for the requested operation
  always @* begin
    next_total = `CYC_LOAD_REG;
    next_corr = `CORR_ZERO;
    next_length = `LEN_TWO;
    case (OP)
      `OP_LOAD_EA: begin
        if (in_memory) begin
          next_corr = corr;
          next_total = `CYC_LOAD_MEM + mode_cycles + corr;
          next_length = `LEN_TWO + ext_bytes;
        end else begin
          next_total = `CYC_LOAD_REG;
          next_length = `LEN_TWO;
        end
      end
      `OP_LOAD_IMM: begin
        next_total = `CYC_LOAD_IMM;
        next_length = `LEN_FIVE;
      end
      `OP_LOAD_STACK, `OP_STORE_STACK: begin
        next_corr = corr;
        next_total = `CYC_STACK + corr;
        next_length = `LEN_THREE;
      end
      `OP_LOAD_PHYS, `OP_STORE_PHYS: begin
        next_corr = corr;
        next_total = `CYC_PHYS + corr;
        next_length = `LEN_FIVE;
      end
      `OP_LOAD_IND: begin
        next_corr = corr;
        next_total = `CYC_LOAD_IND + corr;
        next_length = `LEN_TWO;
      end
      `OP_STORE_IND: begin
        next_corr = corr;
        next_total = `CYC_STORE_IND + corr;
        next_length = `LEN_TWO;
      end
      `OP_STORE_EA: begin
        if (in_memory) begin
          next_corr = corr;
          next_total = `CYC_STORE_MEM + mode_cycles + corr;
          next_length = `LEN_TWO + ext_bytes;
        end else begin
          next_total = `CYC_STORE_REG;
          next_length = `LEN_TWO;
        end
      end
      `OP_ADD_ONE, `OP_SUB_ONE: begin
        next_length = `LEN_TWO + ext_bytes;
        if (in_memory) begin
          // Read then write back, so the correction is paid twice
          next_corr = {corr[4:0], 1'b0};
          if (SIZE == `SIZE_LONG)
            next_total = `CYC_STEP_MEM_L + mode_cycles +
                         {corr[4:0], 1'b0};
          else
            next_total = `CYC_STEP_MEM_BW + mode_cycles +
                         {corr[4:0], 1'b0};
        end else if (SIZE == `SIZE_LONG) begin
          next_total = `CYC_STEP_REG_L;
        end else begin
          next_total = `CYC_STEP_REG_BW;
        end
      end
      `OP_CMP_EA: begin
        next_length = `LEN_TWO + ext_bytes;
        if (in_memory) begin
          next_corr = corr;
          if (SIZE == `SIZE_LONG)
            next_total = `CYC_CMP_MEM_L + mode_cycles + corr;
          else
            next_total = `CYC_CMP_MEM_BW + mode_cycles + corr;
        end else if (SIZE == `SIZE_LONG) begin
          next_total = `CYC_CMP_REG_L;
        end else begin
          next_total = `CYC_CMP_REG_BW;
        end
      end
      `OP_CMP_IMM: begin
        next_total = (SIZE == `SIZE_LONG) ? `CYC_CMP_IMM_L : `CYC_CMP_IMM_BW;
        next_length = (SIZE == `SIZE_LONG) ? `LEN_FIVE :
                      (SIZE == `SIZE_WORD) ? `LEN_THREE : `LEN_TWO;
      end
      `OP_CMP_HALVES: begin
        next_total = `CYC_CMP_HALVES;
        next_length = `LEN_ONE;
      end
      default: begin
        next_total = `CYC_LOAD_REG;
      end
    endcase
  end

  // Arithmetic operands from the captured instruction
  always @* begin
    alu_a = ACC;
    alu_b = operand;
    alu_sub = 1'b1;
    alu_size = size;
    case (op)
      `OP_ADD_ONE: begin
        alu_a = operand;
        alu_b = 32'h00000001;
        alu_sub = 1'b0;
      end
      `OP_SUB_ONE: begin
        alu_a = operand;
        alu_b = 32'h00000001;
      end
      `OP_CMP_HALVES: begin
        // High half against low half of the accumulator
        alu_size = (size == `SIZE_BYTE) ? `SIZE_BYTE : `SIZE_WORD;
        alu_a = (size == `SIZE_BYTE) ? {24'h000000, ACC[23:16]} :
                {16'h0000, ACC[31:16]};
        alu_b = (size == `SIZE_BYTE) ? {24'h000000, ACC[7:0]} :
                {16'h0000, ACC[15:0]};
      end
      default: begin
        // Compare of accumulator and operand at the chosen size
        alu_a = (size == `SIZE_BYTE) ? {24'h000000, ACC[7:0]} :
                (size == `SIZE_WORD) ? {16'h0000, ACC[15:0]} : ACC;
        alu_b = (size == `SIZE_BYTE) ? {24'h000000, operand[7:0]} :
                (size == `SIZE_WORD) ? {16'h0000, operand[15:0]} : operand;
      end
    endcase
  end

  step_compare_alu u_alu (
    .a(alu_a),
    .b(alu_b),
    .subtract(alu_sub),
    .size(alu_size),
    .result(alu_result),
    .neg(alu_n),
    .zero(alu_z),
    .ovf(alu_v),
    .carry(alu_c)
  );

  // Sequencer: take a request, count its cycles, commit on the last one
  always @(posedge REF_CLK) begin
    if (RST) begin
      state <= ST_IDLE;
      op <= `OP_LOAD_EA;
      size <= `SIZE_BYTE;
      operand <= 32'h00000000;
      count <= 6'h00;
      total <= 6'h00;
      BUSY <= 1'b0;
      DONE <= 1'b0;
      ACC <= `ACC_RESET;
      WRITE_DATA <= 32'h00000000;
      WRITE_EN <= 1'b0;
      READ_MODIFY_WRITE_ATTR <= 1'b0;
      PHYS_ADDR <= 24'h000000;
      CYCLES <= 6'h00;
      CORRECTION <= 6'h00;
      LENGTH <= 4'h0;
      FLAG_N <= 1'b0;
      FLAG_Z <= 1'b0;
      FLAG_V <= 1'b0;
      FLAG_C <= 1'b0;
    end else begin
      DONE <= 1'b0;
      WRITE_EN <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (START) begin
            state <= ST_BUSY;
            BUSY <= 1'b1;
            op <= OP;
            size <= (OP <= `OP_STORE_EA) ? `SIZE_LONG : SIZE;
            operand <= OPERAND;
            count <= 6'h01;
            total <= next_total;
            CYCLES <= next_total;
            CORRECTION <= next_corr;
            LENGTH <= next_length;
            PHYS_ADDR <= ACC[23:0]; // Address for the indirect forms
            READ_MODIFY_WRITE_ATTR <= (OP == `OP_ADD_ONE) ||
                                      (OP == `OP_SUB_ONE);
          end
        end
        ST_BUSY: begin
          if (count != total) begin
            count <= count + 6'h01;
          end else begin
            state <= ST_IDLE;
            BUSY <= 1'b0;
            DONE <= 1'b1;
            READ_MODIFY_WRITE_ATTR <= 1'b0;
            case (op)
              `OP_LOAD_EA, `OP_LOAD_IMM, `OP_LOAD_STACK, `OP_LOAD_PHYS,
              `OP_LOAD_IND: begin
                ACC <= operand;
                FLAG_N <= operand[31];
                FLAG_Z <= (operand == 32'h00000000);
              end
              `OP_STORE_IND: begin
                WRITE_DATA <= operand;
                WRITE_EN <= 1'b1;
                FLAG_N <= operand[31];
                FLAG_Z <= (operand == 32'h00000000);
              end
              `OP_STORE_STACK, `OP_STORE_PHYS, `OP_STORE_EA: begin
                WRITE_DATA <= ACC;
                WRITE_EN <= 1'b1;
                FLAG_N <= ACC[31];
                FLAG_Z <= (ACC == 32'h00000000);
              end
              `OP_ADD_ONE, `OP_SUB_ONE: begin
                // Carry left alone on purpose
                WRITE_DATA <= alu_result;
                WRITE_EN <= 1'b1;
                FLAG_N <= alu_n;
                FLAG_Z <= alu_z;
                FLAG_V <= alu_v;
              end
              `OP_CMP_EA, `OP_CMP_IMM, `OP_CMP_HALVES: begin
                // No result is stored, only the four flags
                FLAG_N <= alu_n;
                FLAG_Z <= alu_z;
                FLAG_V <= alu_v;
                FLAG_C <= alu_c;
              end
              default: begin
                FLAG_N <= FLAG_N;
              end
            endcase
          end
        end
        default: begin
          state <= ST_IDLE;
          BUSY <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: mem_side_model.sv */
// Memory side model: eight long words of data space and the last written word.
// Assumes the bench hands it the accumulator as the read address.
`default_nettype none
module mem_side_model (
  input wire logic REF_CLK,
  input wire logic [23:0] addr,
  input wire logic [23:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  output logic [31:0] rd_data,
  output logic [31:0] last_write
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [8];
  // Known fill so a fetched long can be predicted
  initial begin
    for (int i = 0; i < 8; i++) mem[i] = 32'hc0de0000 | i;
    last_write = 32'h0;
  end
  // Outside the modelled words the data reads back inverted, not stale
  assign rd_data = (addr[23:5] == 19'h0) ? mem[addr[4:2]] : ~mem[addr[4:2]];
  // Writes land on the edge after the commit edge, while the strobe is high
  always @(posedge REF_CLK) begin
    if (wr_en) begin
      mem[wr_addr[4:2]] <= wr_data;
      last_write <= wr_data;
    end
  end
endmodule
`default_nettype wire

/* File: step_compare_alu.v */
// Add-one, subtract-one and compare arithmetic at byte, word or long size.
// Assumes operands arrive zero-extended; combinational only.
`include "exec_timing_map.vh"
`default_nettype none
module step_compare_alu (
  input wire [31:0] a,
  input wire [31:0] b,
  input wire subtract,
  input wire [1:0] size,
  output reg [31:0] result,
  output reg neg,
  output reg zero,
  output reg ovf,
  output reg carry
);
  reg [32:0] raw;
  reg sa;
  reg sb;
  // Sign and carry taken at the operand's own top bit
  always @* begin
    raw = subtract ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
    result = raw[31:0];
    sa = a[31];
    sb = b[31];
    carry = raw[32];
    case (size)
      `SIZE_BYTE: begin
        result = {24'h000000, raw[7:0]};
        sa = a[7];
        sb = b[7];
        carry = raw[8];
      end
      `SIZE_WORD: begin
        result = {16'h0000, raw[15:0]};
        sa = a[15];
        sb = b[15];
        carry = raw[16];
      end
      default: begin
        result = raw[31:0];
      end
    endcase
    neg = (size == `SIZE_BYTE) ? result[7] :
          (size == `SIZE_WORD) ? result[15] : result[31];
    zero = (result == 32'h00000000);
    // Signed wrap: operand signs disagree with the result sign
    if (subtract) ovf = (sa != sb) && (neg != sa);
    else ovf = (sa == sb) && (neg != sa);
  end
endmodule
`default_nettype wire

/* File: tb_cpu_long_move_incdec_compare.sv */
// Bench for the long move, add/subtract-one and compare unit.
// Assumes the timing map header, the memory model and the port checker.
`default_nettype none
`include "exec_timing_map.vh"
module tb_cpu_long_move_incdec_compare;
  timeunit 1ns;
  timeprecision 1ps;
  logic REF_CLK = 1'b0;
  logic RST = 1'b1;
  logic START = 1'b0;
  logic [3:0] OP = 4'h0;
  logic [1:0] SIZE = 2'h0;
  logic [4:0] MODE = 5'h00;
  logic [2:0] LOC = 3'h0;
  logic [31:0] OPERAND = 32'h0;
  wire logic BUSY, DONE, WRITE_EN, READ_MODIFY_WRITE_ATTR;
  wire logic FLAG_N, FLAG_Z, FLAG_V, FLAG_C;
  wire logic [31:0] ACC, WRITE_DATA, mem_data, last_write;
  wire logic [23:0] PHYS_ADDR;
  wire logic [5:0] CYCLES, CORRECTION;
  wire logic [3:0] LENGTH;
  int failures = 0;
  int total_checks = 0;
  long_move_step_compare dut (.REF_CLK(REF_CLK), .RST(RST), .START(START),
    .OP(OP), .SIZE(SIZE), .MODE(MODE), .LOC(LOC), .OPERAND(OPERAND),
    .BUSY(BUSY), .DONE(DONE), .ACC(ACC), .WRITE_DATA(WRITE_DATA),
    .WRITE_EN(WRITE_EN), .READ_MODIFY_WRITE_ATTR(READ_MODIFY_WRITE_ATTR),
    .PHYS_ADDR(PHYS_ADDR), .CYCLES(CYCLES), .CORRECTION(CORRECTION),
    .LENGTH(LENGTH), .FLAG_N(FLAG_N), .FLAG_Z(FLAG_Z), .FLAG_V(FLAG_V),
    .FLAG_C(FLAG_C));
  mem_side_model mdl (.REF_CLK(REF_CLK), .addr(ACC[23:0]),
    .wr_addr(PHYS_ADDR), .wr_data(WRITE_DATA), .wr_en(WRITE_EN),
    .rd_data(mem_data), .last_write(last_write));
  // Free-running core clock
  initial forever #5 REF_CLK = ~REF_CLK;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Issue one instruction at this falling edge, return in its commit cycle;
  // poke keeps start up a cycle with another code while the unit is busy
  task automatic exec(input logic [3:0] op, input logic [1:0] sz,
      input logic [4:0] md, input logic [2:0] lc, input logic [31:0] v,
      input logic [5:0] cy, input logic [5:0] co, input logic [3:0] ln,
      input logic poke);
    int n;
    START = 1'b1;
    OP = op;
    SIZE = sz;
    MODE = md;
    LOC = lc;
    OPERAND = v;
    @(negedge REF_CLK);
    n = 1;
    if (poke) begin
      OP = `OP_LOAD_IMM;
      @(negedge REF_CLK);
      n = 2;
    end
    START = 1'b0;
    while (DONE !== 1'b1 && n < 40) begin
      @(negedge REF_CLK);
      n++;
    end
    if (n >= 40) begin
      failures++;
      finish_test();
    end else begin
      chk(n - 1, cy);
      chk(CYCLES, cy);
      chk(CORRECTION, co);
      chk(LENGTH, ln);
    end
  endtask
  // Every location against every size, compare through plain indirect
  task automatic corr_table();
    logic [5:0] cb [6] = '{6'h0, 6'h0, 6'h0, 6'h1, 6'h1, 6'h1};
    logic [5:0] cw [6] = '{6'h0, 6'h0, 6'h1, 6'h1, 6'h3, 6'h3};
    logic [5:0] cl [6] = '{6'h0, 6'h0, 6'h2, 6'h2, 6'h6, 6'h6};
    logic [5:0] c;
    for (int l = 0; l < 6; l++) begin
      for (int s = 0; s < 3; s++) begin
        c = (s == 0) ? cb[l] : (s == 1) ? cw[l] : cl[l];
        exec(`OP_CMP_EA, s, 5'h08, l, 32'h0,
          ((s == 2) ? 6'h05 : 6'h03) + c, c, 4'h2, 1'b0);
      end
    end
  endtask
  // Flags around long moves, all load and store forms
  task automatic move_tests();
    exec(`OP_LOAD_IMM, 2'h2, 5'h00, 3'h0, 32'h00120034, 6'h3, 6'h0, 4'h5, 0);
    exec(`OP_CMP_HALVES, 2'h0, 5'h00, 3'h0, 32'h0, 6'h2, 6'h0, 4'h1, 1'b0);
    chk({FLAG_N, FLAG_Z, FLAG_V, FLAG_C}, 4'h9);
    exec(`OP_ADD_ONE, 2'h0, 5'h00, 3'h0, 32'h7f, 6'h2, 6'h0, 4'h2, 1'b0);
    chk({FLAG_N, FLAG_Z, FLAG_V, FLAG_C}, 4'hb);
    chk(WRITE_DATA, 32'h80);
    chk(WRITE_EN, 1'b1);
    exec(`OP_LOAD_EA, 2'h2, 5'h00, 3'h0, 32'h0, 6'h1, 6'h0, 4'h2, 1'b0);
    chk({FLAG_N, FLAG_Z, FLAG_V, FLAG_C}, 4'h7);
    exec(`OP_LOAD_STACK, 2'h2, 5'h00, 3'h4, 32'h1, 6'h0a, 6'h6, 4'h3, 0);
    exec(`OP_LOAD_PHYS, 2'h2, 5'h00, 3'h2, 32'h10, 6'h6, 6'h2, 4'h5, 0);
    exec(`OP_LOAD_IND, 2'h2, 5'h00, 3'h0, mem_data, 6'h3, 6'h0, 4'h2, 0);
    chk(ACC, 32'hc0de0004);
    exec(`OP_LOAD_EA, 2'h2, 5'h0c, 3'h3, 32'h80, 6'h9, 6'h2, 4'h2, 0);
    chk(ACC, 32'h80);
    exec(`OP_LOAD_EA, 2'h2, 5'h1f, 3'h0, 32'h5, 6'h4, 6'h0, 4'h4, 0);
    exec(`OP_STORE_EA, 2'h2, 5'h00, 3'h0, 32'h0, 6'h2, 6'h0, 4'h2, 0);
    exec(`OP_STORE_EA, 2'h2, 5'h08, 3'h5, 32'h0, 6'h0a, 6'h6, 4'h2, 0);
    chk(WRITE_DATA, 32'h5);
    exec(`OP_STORE_STACK, 2'h2, 5'h00, 3'h1, 32'h0, 6'h4, 6'h0, 4'h3, 0);
    exec(`OP_STORE_PHYS, 2'h2, 5'h00, 3'h4, 32'h0, 6'h0a, 6'h6, 4'h5, 0);
    exec(`OP_STORE_IND, 2'h2, 5'h00, 3'h2, 32'h80000009, 6'h7, 6'h2, 4'h2, 0);
    chk(WRITE_DATA, 32'h80000009);
    chk({FLAG_N, FLAG_Z, FLAG_V, FLAG_C}, 4'hb);
  endtask
  // Add and subtract one: register at word and long, memory at each size
  task automatic step_tests();
    exec(`OP_SUB_ONE, 2'h1, 5'h00, 3'h0, 32'h8000, 6'h2, 6'h0, 4'h2, 0);
    chk({FLAG_N, FLAG_Z, FLAG_V, FLAG_C}, 4'h3);
    chk(WRITE_DATA, 32'h7fff);
    exec(`OP_ADD_ONE, 2'h2, 5'h00, 3'h0, 32'hffffffff, 6'h4, 6'h0, 4'h2, 0);
    chk({FLAG_N, FLAG_Z, FLAG_V, FLAG_C}, 4'h5);
    exec(`OP_SUB_ONE, 2'h2, 5'h10, 3'h4, 32'h1, 6'h12, 6'h0c, 4'h3, 1);
    chk(WRITE_DATA, 32'h0);
    exec(`OP_SUB_ONE, 2'h0, 5'h1f, 3'h3, 32'h0, 6'h6, 6'h2, 4'h4, 0);
    chk({FLAG_N, FLAG_Z, FLAG_V, FLAG_C}, 4'h9);
    exec(`OP_ADD_ONE, 2'h1, 5'h0c, 3'h4, 32'hffff, 6'h0d, 6'h6, 4'h2, 0);
    chk({FLAG_N, FLAG_Z, FLAG_V, FLAG_C}, 4'h5);
  endtask
  // Compares leave the accumulator and set all four flags
  task automatic cmp_tests();
    exec(`OP_LOAD_IMM, 2'h2, 5'h00, 3'h0, 32'h12345678, 6'h3, 6'h0, 4'h5, 0);
    exec(`OP_CMP_IMM, 2'h2, 5'h00, 3'h0, 32'h12345678, 6'h3, 6'h0, 4'h5, 0);
    chk({FLAG_N, FLAG_Z, FLAG_V, FLAG_C}, 4'h4);
    exec(`OP_CMP_IMM, 2'h0, 5'h00, 3'h0, 32'h79, 6'h2, 6'h0, 4'h2, 0);
    chk({FLAG_N, FLAG_Z, FLAG_V, FLAG_C}, 4'h9);
    exec(`OP_CMP_IMM, 2'h1, 5'h00, 3'h0, 32'h5678, 6'h2, 6'h0, 4'h3, 0);
    chk({FLAG_N, FLAG_Z, FLAG_V, FLAG_C}, 4'h4);
    exec(`OP_CMP_EA, 2'h2, 5'h1c, 3'h1, 32'h80000000, 6'h6, 6'h0, 4'h2, 0);
    chk({FLAG_N, FLAG_Z, FLAG_V, FLAG_C}, 4'hb);
    chk(ACC, 32'h12345678);
  endtask
  // Reset, then the scenarios back to back
  initial begin
    repeat (12) @(posedge REF_CLK);
    @(negedge REF_CLK);
    RST = 1'b0;
    chk(ACC, `ACC_RESET);
    chk({BUSY, DONE, FLAG_N, FLAG_Z, FLAG_V, FLAG_C}, 6'h00);
    corr_table();
    move_tests();
    step_tests();
    cmp_tests();
    @(negedge REF_CLK);
    chk(last_write, 32'h0);
    finish_test();
  end
endmodule
bind long_move_step_compare lmsc_asserts chk_i (.REF_CLK(REF_CLK),
  .RST(RST), .START(START), .OP(OP), .SIZE(SIZE), .MODE(MODE), .LOC(LOC),
  .OPERAND(OPERAND), .BUSY(BUSY), .DONE(DONE), .ACC(ACC),
  .WRITE_DATA(WRITE_DATA), .WRITE_EN(WRITE_EN),
  .READ_MODIFY_WRITE_ATTR(READ_MODIFY_WRITE_ATTR), .PHYS_ADDR(PHYS_ADDR),
  .CYCLES(CYCLES), .CORRECTION(CORRECTION), .LENGTH(LENGTH),
  .FLAG_N(FLAG_N), .FLAG_Z(FLAG_Z), .FLAG_V(FLAG_V), .FLAG_C(FLAG_C));
`default_nettype wire
